// [rtl/aux_irq_defines.vh]
`ifndef AUX_IRQ_DEFINES_VH
`define AUX_IRQ_DEFINES_VH
// ****************************************
// register addresses
// ****************************************
`define ADDR_AUX_PENDING_INDEX  8'ha5
`define ADDR_AUX_IRQ_MASK       8'ha6
`define ADDR_AUX_MASKED_STATUS  8'ha7
`define ADDR_STANDARD_IRQ_MASK  8'ha8
`define ADDR_BREAK_CONTROL      8'ha9
`define ADDR_BREAK_ADDR_LOW     8'haa
`define ADDR_BREAK_ADDR_HIGH    8'hab
// ****************************************
// reset values
// ****************************************
`define RST_BYTE                8'h00
`define RST_INDEX               4'h0
`define RST_ADDR16              16'h0000
`define RST_STD_REQ             7'h00
// ****************************************
// field positions
// ****************************************
`define BIT_GLOBAL_GATE         7
`define BIT_UART1               6
`define BIT_TIMER2              5
`define BIT_UART0               4
`define BIT_TIMER1              3
`define BIT_EXT1                2
`define BIT_TIMER0              1
`define BIT_EXT0                0
`define BIT_BREAK_HIT           7
`define BIT_MEM_SELECT          1
`define BIT_ARM_ENABLE          0
`define AUX_VECTOR_ADDR         16'h0033
`define NUM_BREAKPOINTS         2
`endif

// [rtl/breakpoint_slot.v]
`timescale 1ns/1ps
`default_nettype none
`include "aux_irq_defines.vh"
// ****************************************
// one breakpoint comparator slot
// ****************************************
module breakpoint_slot (
    input  wire        clk,          // core clock
    input  wire        resetn,       // sync reset, active low
    input  wire        arm_wr,       // control write for this slot
    input  wire        hit_clr,      // clear hit for this slot
    input  wire        wr_mem_sel,   // memory select to load
    input  wire        wr_enable,    // enable to load
    input  wire [15:0] wr_addr,      // compare address to load
    input  wire        data_acc,     // data memory access strobe
    input  wire [15:0] data_addr,    // data memory address
    input  wire        prog_acc,     // program fetch strobe
    input  wire [15:0] prog_addr,    // program address
    output reg         hit_ff        // sticky match
);
    reg        mem_sel_ff;
    reg        enable_ff;
    reg [15:0] addr_ff;
    wire       match;

    assign match = enable_ff & (mem_sel_ff ? (prog_acc & (prog_addr == addr_ff))
                                           : (data_acc & (data_addr == addr_ff)));

    always @(posedge clk) begin
        if (!resetn) begin
            mem_sel_ff <= 1'b0;
            enable_ff  <= 1'b0;
            addr_ff    <= `RST_ADDR16;
            hit_ff     <= 1'b0;
        end else begin
            if (arm_wr) begin
                mem_sel_ff <= wr_mem_sel;
                enable_ff  <= wr_enable;
                addr_ff    <= wr_addr;
            end
            if (match)
                hit_ff <= 1'b1;
            else if (hit_clr)
                hit_ff <= 1'b0;
        end
    end
endmodule // breakpoint_slot
`default_nettype wire

// [rtl/aux_interrupt_and_breakpoint_unit.v]
// Contract
// - pending index names highest pending aux source, 0 none, 1..8 by source
// - all aux sources request one shared vector address
// - writing aux enable stores mask, 0 masked, 1 enabled
// - reading aux enable returns raw source requests, not mask
// - bit 0 source highest aux priority, bit 7 lowest
// - aux group gated by extended control bit 4
// - global gate ignores aux sources, blocks all standard sources at 0
// - aux status bit is raw request and mask
// - serial receive and two-wire status share bit 2 and code 3
// - digital undervolt and breakpoint hit share bit 0
// - standard bits 6 and 4 enable uart1 and uart0 rx or tx
// - standard bits 5, 3, 1 enable timer 2, 1, 0 overflow
// - standard bits 2 and 0 enable external pins 1 and 0
// - control write arms selected breakpoint from written control byte and address bytes
// - hit reads any match; writing 1 clears selected unless it matches that same cycle, 0 nothing
// - memory select 0 data space, 1 program space
// - breakpoint enable bit turns matching on or off
// - compare address is 16 bits from low and high bytes
`timescale 1ns/1ps
`default_nettype none
`include "aux_irq_defines.vh"
module aux_interrupt_and_breakpoint_unit (
    input  wire        clk,                    // core clock, 100 MHz
    input  wire        resetn,                 // sync reset, active low
    input  wire [7:0]  sfr_addr,               // special register address
    input  wire [7:0]  sfr_wdata,              // write data
    input  wire        sfr_wr,                 // write strobe
    input  wire        sfr_rd,                 // read strobe
    output reg  [7:0]  sfr_rdata_ff,           // registered read data
    output reg         sfr_hit_ff,             // read addressed this block
    input  wire        aux_group_gate,         // extended control bit 4
    input  wire        breakpoint_selector,    // selected breakpoint slot
    input  wire        one_hz_tick_flag,       // seconds timer request
    input  wire        accum_done_flag,        // accumulator request
    input  wire        conv_done_flag,         // converter request
    input  wire        kilohertz_tick_flag,    // millisecond timer request
    input  wire        serial_tx_flag,         // serial transmit request
    input  wire        serial_rx_flag,         // serial receive request
    input  wire        twowire_flag,           // two-wire status request
    input  wire        analog_undervolt_flag,  // analog low voltage request
    input  wire        digital_undervolt_flag, // digital low voltage request
    input  wire        uart1_rx_flag,          // uart 1 receive flag
    input  wire        uart1_tx_flag,          // uart 1 transmit flag
    input  wire        uart0_rx_flag,          // uart 0 receive flag
    input  wire        uart0_tx_flag,          // uart 0 transmit flag
    input  wire        timer2_ovf_flag,        // timer 2 overflow
    input  wire        timer1_ovf_flag,        // timer 1 overflow
    input  wire        timer0_ovf_flag,        // timer 0 overflow
    input  wire        ext_pin1_req,           // external pin 1 request
    input  wire        ext_pin0_req,           // external pin 0 request
    input  wire        data_acc,               // data memory access strobe
    input  wire [15:0] data_addr,              // data memory address
    input  wire        prog_acc,               // program fetch strobe
    input  wire [15:0] prog_addr,              // program address
    output reg         aux_irq_req_ff,         // aux group request
    output wire [15:0] aux_vector,             // shared aux vector
    output reg  [6:0]  std_irq_req_ff,         // gated standard requests
    output wire        breakpoint_hit_flag     // any breakpoint matched
);
    // ****************************************
    // state
    // ****************************************
    reg  [7:0] aux_irq_mask_ff;
    reg  [7:0] standard_irq_mask_ff;
    reg  [7:0] break_ctrl_ff;
    reg  [7:0] breakpoint_addr_low_ff;
    reg  [7:0] breakpoint_addr_high_ff;
    reg  [3:0] aux_pending_index_ff;
    reg  [3:0] nxt_aux_pending_index;
    reg  [7:0] nxt_rdata;
    reg        nxt_hit;
    wire [7:0] aux_raw;
    wire [7:0] aux_masked;
    wire [`NUM_BREAKPOINTS-1:0] slot_hit;
    wire       ctrl_wr;
    wire       global_irq_gate;
    wire       sel_slot0;
    wire       sel_slot1;
    wire       wr_aux_mask;
    wire       wr_std_mask;
    wire       wr_break_low;
    wire       wr_break_high;
    wire       rx_merged;
    wire       undervolt_merged;
    wire       uart1_req;
    wire       uart0_req;
    wire [6:0] std_src;
    wire [6:0] std_gated;
    wire [7:0] break_status;

    assign ctrl_wr = sfr_wr & (sfr_addr == `ADDR_BREAK_CONTROL);

    // ****************************************
    // write decode
    // ****************************************
    // index and status addresses have no strobe: read only
    assign wr_aux_mask   = sfr_wr & (sfr_addr == `ADDR_AUX_IRQ_MASK);
    assign wr_std_mask   = sfr_wr & (sfr_addr == `ADDR_STANDARD_IRQ_MASK);
    assign wr_break_low  = sfr_wr & (sfr_addr == `ADDR_BREAK_ADDR_LOW);
    assign wr_break_high = sfr_wr & (sfr_addr == `ADDR_BREAK_ADDR_HIGH);

    // ****************************************
    // breakpoint slots
    // ****************************************
    // selector picks the slot that a control write arms or clears
    assign sel_slot0 = ~breakpoint_selector;
    assign sel_slot1 = breakpoint_selector;

    breakpoint_slot u_slot0 (
        .clk        (clk),
        .resetn     (resetn),
        .arm_wr     (ctrl_wr & sel_slot0),
        .hit_clr    (ctrl_wr & sel_slot0 & sfr_wdata[`BIT_BREAK_HIT]),
        .wr_mem_sel (sfr_wdata[`BIT_MEM_SELECT]),
        .wr_enable  (sfr_wdata[`BIT_ARM_ENABLE]),
        .wr_addr    ({breakpoint_addr_high_ff, breakpoint_addr_low_ff}),
        .data_acc   (data_acc),
        .data_addr  (data_addr),
        .prog_acc   (prog_acc),
        .prog_addr  (prog_addr),
        .hit_ff     (slot_hit[0])
    );

    breakpoint_slot u_slot1 (
        .clk        (clk),
        .resetn     (resetn),
        .arm_wr     (ctrl_wr & sel_slot1),
        .hit_clr    (ctrl_wr & sel_slot1 & sfr_wdata[`BIT_BREAK_HIT]),
        .wr_mem_sel (sfr_wdata[`BIT_MEM_SELECT]),
        .wr_enable  (sfr_wdata[`BIT_ARM_ENABLE]),
        .wr_addr    ({breakpoint_addr_high_ff, breakpoint_addr_low_ff}),
        .data_acc   (data_acc),
        .data_addr  (data_addr),
        .prog_acc   (prog_acc),
        .prog_addr  (prog_addr),
        .hit_ff     (slot_hit[1])
    );

    assign breakpoint_hit_flag = |slot_hit;

    // ****************************************
    // auxiliary group
    // ****************************************
    // receive and two-wire merged
    assign rx_merged        = serial_rx_flag | twowire_flag;
    assign undervolt_merged = digital_undervolt_flag | breakpoint_hit_flag;

    assign aux_raw = {one_hz_tick_flag, accum_done_flag, conv_done_flag,
                      kilohertz_tick_flag, serial_tx_flag, rx_merged,
                      analog_undervolt_flag, undervolt_merged};

    assign aux_masked = aux_raw & aux_irq_mask_ff;

    // bit 0 first, bit 7 last
    always @* begin
        if (aux_masked[0])
            nxt_aux_pending_index = 4'h1;
        else if (aux_masked[1])
            nxt_aux_pending_index = 4'h2;
        else if (aux_masked[2])
            nxt_aux_pending_index = 4'h3;
        else if (aux_masked[3])
            nxt_aux_pending_index = 4'h4;
        else if (aux_masked[4])
            nxt_aux_pending_index = 4'h5;
        else if (aux_masked[5])
            nxt_aux_pending_index = 4'h6;
        else if (aux_masked[6])
            nxt_aux_pending_index = 4'h7;
        else if (aux_masked[7])
            nxt_aux_pending_index = 4'h8;
        else
            nxt_aux_pending_index = `RST_INDEX;
    end

    assign aux_vector = `AUX_VECTOR_ADDR;

    assign global_irq_gate = standard_irq_mask_ff[`BIT_GLOBAL_GATE];

    // ****************************************
    // standard group
    // ****************************************
    // rx or tx per serial port
    assign uart1_req = uart1_rx_flag | uart1_tx_flag;
    assign uart0_req = uart0_rx_flag | uart0_tx_flag;

    // serial ports on bits 6 and 4
    // timers on bits 5, 3 and 1
    // external pins on bits 2 and 0
    assign std_src[`BIT_UART1]  = uart1_req;
    assign std_src[`BIT_TIMER2] = timer2_ovf_flag;
    assign std_src[`BIT_UART0]  = uart0_req;
    assign std_src[`BIT_TIMER1] = timer1_ovf_flag;
    assign std_src[`BIT_EXT1]   = ext_pin1_req;
    assign std_src[`BIT_TIMER0] = timer0_ovf_flag;
    assign std_src[`BIT_EXT0]   = ext_pin0_req;

    // gate 0 overrides every mask bit
    assign std_gated = {7{global_irq_gate}} & standard_irq_mask_ff[6:0] & std_src;

    assign break_status = {breakpoint_hit_flag, 5'h00, break_ctrl_ff[`BIT_MEM_SELECT],
                           break_ctrl_ff[`BIT_ARM_ENABLE]};

    // ****************************************
    // read mux
    // ****************************************
    always @* begin
        nxt_rdata = `RST_BYTE;
        nxt_hit   = 1'b1;
        case (sfr_addr)
            `ADDR_AUX_PENDING_INDEX: nxt_rdata = {4'h0, aux_pending_index_ff};
            `ADDR_AUX_IRQ_MASK:      nxt_rdata = aux_raw;
            `ADDR_AUX_MASKED_STATUS: nxt_rdata = aux_masked;
            `ADDR_STANDARD_IRQ_MASK: nxt_rdata = standard_irq_mask_ff;
            `ADDR_BREAK_CONTROL:     nxt_rdata = break_status;
            `ADDR_BREAK_ADDR_LOW:    nxt_rdata = breakpoint_addr_low_ff;
            `ADDR_BREAK_ADDR_HIGH:   nxt_rdata = breakpoint_addr_high_ff;
            default:                 nxt_hit   = 1'b0;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge clk) begin
        if (!resetn) begin
            aux_irq_mask_ff         <= `RST_BYTE;
            standard_irq_mask_ff    <= `RST_BYTE;
            break_ctrl_ff           <= `RST_BYTE;
            breakpoint_addr_low_ff  <= `RST_BYTE;
            breakpoint_addr_high_ff <= `RST_BYTE;
            aux_pending_index_ff    <= `RST_INDEX;
            sfr_rdata_ff            <= `RST_BYTE;
            sfr_hit_ff              <= 1'b0;
            aux_irq_req_ff          <= 1'b0;
            std_irq_req_ff          <= `RST_STD_REQ;
        end else begin
            aux_pending_index_ff <= nxt_aux_pending_index;
            sfr_rdata_ff         <= sfr_rd ? nxt_rdata : `RST_BYTE;
            sfr_hit_ff           <= sfr_rd & nxt_hit;
            aux_irq_req_ff       <= aux_group_gate & (|aux_masked);
            std_irq_req_ff <= std_gated;
            if (wr_aux_mask)
                aux_irq_mask_ff <= sfr_wdata;
            if (wr_std_mask)
                standard_irq_mask_ff <= sfr_wdata;
            if (ctrl_wr)
                break_ctrl_ff <= sfr_wdata;
            // bytes held until the arming write
            if (wr_break_low)
                breakpoint_addr_low_ff <= sfr_wdata;
            if (wr_break_high)
                breakpoint_addr_high_ff <= sfr_wdata;
        end
    end
endmodule // aux_interrupt_and_breakpoint_unit
`default_nettype wire

// [bench/aux_irq_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module aux_irq_sva (
    input wire logic        clk,                // core clock
    input wire logic        resetn,             // sync reset
    input wire logic [7:0]  sfr_addr,           // address
    input wire logic [7:0]  sfr_wdata,          // write data
    input wire logic        sfr_wr,             // write strobe
    input wire logic        sfr_rd,             // read strobe
    input wire logic [7:0]  sfr_rdata_ff,       // read data
    input wire logic        sfr_hit_ff,         // read hit
    input wire logic        aux_group_gate,     // aux gate
    input wire logic        timer0_ovf_flag,    // timer 0 request
    input wire logic        ext_pin0_req,       // pin 0 request
    input wire logic        aux_irq_req_ff,     // aux request
    input wire logic [15:0] aux_vector,         // aux vector
    input wire logic [6:0]  std_irq_req_ff,     // std requests
    input wire logic        breakpoint_hit_flag // any hit
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence mapped_read;
        sfr_rd && sfr_addr >= 8'ha5 && sfr_addr <= 8'hab;
    endsequence
    sequence gate_off_write;
        sfr_wr && sfr_addr == 8'ha8 && !sfr_wdata[7];
    endsequence
    a_vector_fixed: assert property (aux_vector == 16'h0033)
        else $error("aux vector wrong");
    a_group_gate_off: assert property (!aux_group_gate |=> !aux_irq_req_ff)
        else $error("aux request while gated");
    a_timer0_quiet: assert property (!timer0_ovf_flag |=> !std_irq_req_ff[1])
        else $error("timer 0 request without flag");
    a_ext0_quiet: assert property (!ext_pin0_req |=> !std_irq_req_ff[0])
        else $error("pin 0 request without pin");
    a_global_gate_off: assert property (gate_off_write |=> ##1 std_irq_req_ff == 7'h00)
        else $error("standard request with global gate off");
    a_read_hit: assert property (mapped_read |=> sfr_hit_ff)
        else $error("mapped read not flagged");
    a_idle_zero: assert property (!sfr_rd |=> sfr_rdata_ff == 8'h00)
        else $error("read data without read");
    a_hit_sticky: assert property (breakpoint_hit_flag && !(sfr_wr && sfr_addr == 8'ha9 &&
        sfr_wdata[7]) |=> breakpoint_hit_flag)
        else $error("hit lost without clear");
endmodule // aux_irq_sva
bind aux_interrupt_and_breakpoint_unit aux_irq_sva u_sva (
    .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata_ff(sfr_rdata_ff), .sfr_hit_ff(sfr_hit_ff),
    .aux_group_gate(aux_group_gate), .timer0_ovf_flag(timer0_ovf_flag),
    .ext_pin0_req(ext_pin0_req), .aux_irq_req_ff(aux_irq_req_ff), .aux_vector(aux_vector),
    .std_irq_req_ff(std_irq_req_ff), .breakpoint_hit_flag(breakpoint_hit_flag));
`default_nettype wire

// [bench/core_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// core side register master
// ****
module core_bus_model (
    input  wire logic       clk,          // core clock
    input  wire logic [7:0] sfr_rdata_ff, // read data
    output var  logic [7:0] sfr_addr,     // address
    output var  logic [7:0] sfr_wdata,    // write data
    output var  logic       sfr_wr,       // write strobe
    output var  logic       sfr_rd        // read strobe
);
    initial {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = 18'h00000;
    // idle bus shows inverted lines, not the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        {sfr_addr, sfr_wdata, sfr_wr} = {a, v, 1'b1};
        @(negedge clk);
        {sfr_addr, sfr_wdata, sfr_wr} = {~a, ~v, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        {sfr_addr, sfr_rd} = {a, 1'b1};
        @(negedge clk);
        {sfr_addr, sfr_rd} = {~a, 1'b0};
        v = sfr_rdata_ff;
    endtask
endmodule // core_bus_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, resetn, gate, sel, twowire, dacc, pacc, wr, rd, hit_rd, aux_req, hit;
    logic [7:0]  aux_in, d, m, f, addr, wdata, rdata;
    logic [8:0]  std_in;
    logic [15:0] daddr, paddr, vec;
    logic [6:0]  std_req;
    logic [3:0]  x;
    int          i, bad_count, samples_checked, cycles;
    logic [19:0] rows [10] = '{20'hff000, 20'hffff1, 20'hfeff2, 20'hff0c3, 20'hf7185,
                               20'h7fc07, 20'hff808, 20'hff206, 20'hff084, 20'h00ff0};
    aux_interrupt_and_breakpoint_unit dut (.clk(clk), .resetn(resetn), .sfr_addr(addr),
        .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata_ff(rdata), .sfr_hit_ff(hit_rd),
        .aux_group_gate(gate), .breakpoint_selector(sel), .one_hz_tick_flag(aux_in[7]),
        .accum_done_flag(aux_in[6]), .conv_done_flag(aux_in[5]), .kilohertz_tick_flag(aux_in[4]),
        .serial_tx_flag(aux_in[3]), .serial_rx_flag(aux_in[2]), .twowire_flag(twowire),
        .analog_undervolt_flag(aux_in[1]), .digital_undervolt_flag(aux_in[0]),
        .uart1_rx_flag(std_in[8]), .uart1_tx_flag(std_in[7]), .timer2_ovf_flag(std_in[6]),
        .uart0_rx_flag(std_in[5]), .uart0_tx_flag(std_in[4]), .timer1_ovf_flag(std_in[3]),
        .ext_pin1_req(std_in[2]), .timer0_ovf_flag(std_in[1]), .ext_pin0_req(std_in[0]),
        .data_acc(dacc), .data_addr(daddr), .prog_acc(pacc), .prog_addr(paddr),
        .aux_irq_req_ff(aux_req), .aux_vector(vec), .std_irq_req_ff(std_req),
        .breakpoint_hit_flag(hit));
    core_bus_model u_core (.clk(clk), .sfr_rdata_ff(rdata), .sfr_addr(addr), .sfr_wdata(wdata),
        .sfr_wr(wr), .sfr_rd(rd));
    always #5 clk = ~clk;
    always @(posedge clk) if (++cycles == 5000) begin bad_count++; summarize(); end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic access(input logic p, input logic [15:0] a);
        @(negedge clk);
        {pacc, dacc, paddr, daddr} = {p, !p, a, a};
        @(negedge clk);
        {pacc, dacc, paddr, daddr} = {2'b00, ~a, ~a};
        @(negedge clk);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {clk, resetn, gate, sel, twowire, dacc, pacc, aux_in, std_in} = {7'h10, 17'h0};
        {daddr, paddr} = 32'h0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        for (i = 0; i < 7; i++) begin
            u_core.rd(8'ha5 + 8'(i), d);
            chk(d, 8'h00, "reset value");
        end
        u_core.rd(8'hac, d);
        chk({d[7:1], hit_rd | d[0]}, 8'h00, "unmapped read");
        chk(vec[7:0], 8'h33, "shared vector low");
        chk(vec[15:8], 8'h00, "shared vector high");
        u_core.wr(8'ha5, 8'hff);
        u_core.rd(8'ha5, d);
        chk(d, 8'h00, "index written");
        $display("test reset done");
        for (i = 0; i < 10; i++) begin
            {m, f, x} = rows[i];
            aux_in = f;
            u_core.wr(8'ha6, m);
            repeat (2) @(negedge clk);
            u_core.rd(8'ha6, d);
            chk(d, f, "raw requests");
            u_core.rd(8'ha7, d);
            chk(d, f & m, "masked status");
            u_core.rd(8'ha5, d);
            chk(d, {4'h0, x}, "pending index");
            chk({7'h0, aux_req}, {7'h0, |(f & m)}, "group request");
        end
        u_core.wr(8'ha6, 8'hff);
        {gate, aux_in} = 9'h0ff;
        repeat (2) @(negedge clk);
        chk({7'h0, aux_req}, 8'h00, "gated group");
        {gate, aux_in, twowire} = 10'h201;
        repeat (2) @(negedge clk);
        u_core.rd(8'ha5, d);
        chk(d, 8'h03, "two-wire index");
        chk({7'h0, aux_req}, 8'h01, "ungated group");
        twowire = 1'b0;
        $display("test aux done");
        std_in = 9'h0ef;
        for (i = 0; i < 7; i++) begin
            u_core.wr(8'ha8, 8'h80 | (8'h01 << i));
            repeat (2) @(negedge clk);
            chk({1'b0, std_req}, 8'h01 << i, "standard mask");
        end
        u_core.wr(8'ha8, 8'h7f);
        repeat (2) @(negedge clk);
        chk({1'b0, std_req}, 8'h00, "global gate");
        std_in = 9'h110;
        u_core.wr(8'ha8, 8'hd0);
        repeat (2) @(negedge clk);
        chk({1'b0, std_req}, 8'h50, "other serial flags");
        $display("test standard done");
        // address bytes before the arming write
        u_core.wr(8'haa, 8'h34);
        u_core.wr(8'hab, 8'h12);
        u_core.wr(8'ha9, 8'h03);
        access(1'b0, 16'h1234);
        chk({7'h0, hit}, 8'h00, "data space ignored");
        access(1'b1, 16'h1235);
        chk({7'h0, hit}, 8'h00, "near address");
        access(1'b1, 16'h1234);
        u_core.rd(8'ha9, d);
        chk(d, 8'h83, "program hit");
        u_core.rd(8'ha6, d);
        chk(d, 8'h01, "hit on bit 0");
        u_core.wr(8'ha9, 8'h03);
        chk({7'h0, hit}, 8'h01, "zero write");
        sel = 1'b1;
        u_core.wr(8'ha9, 8'h80);
        chk({7'h0, hit}, 8'h01, "other slot clear");
        sel = 1'b0;
        u_core.wr(8'ha9, 8'h80);
        chk({7'h0, hit}, 8'h00, "slot clear");
        access(1'b1, 16'h1234);
        chk({7'h0, hit}, 8'h00, "disabled slot");
        u_core.wr(8'ha9, 8'h01);
        access(1'b0, 16'h1234);
        chk({7'h0, hit}, 8'h01, "data hit");
        $display("test breakpoint done");
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        u_core.rd(8'ha9, d);
        chk(d, 8'h00, "hit after mid-run reset");
        u_core.rd(8'ha8, d);
        chk(d, 8'h00, "mask after mid-run reset");
        $display("test mid-run reset done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
